// ---- inc/ecp_port_defs.svh ----
// register offsets, field positions, codes and sizes for the ecp host port
// assumes inclusion by bare name from the package and the design modules
`ifndef ECP_PORT_DEFS_SVH
`define ECP_PORT_DEFS_SVH

// register indices on the plain register port
`define REG_DATA      3'h0
`define REG_DSR       3'h1
`define REG_DCR       3'h2
`define REG_CFGA      3'h3
`define REG_ECR       3'h4
`define REG_INT_STAT  3'h5
`define REG_INT_MASK  3'h6

// port word geometry and fifo depth
`define WORD_BYTES    2
`define WORD_W        16
`define BYTE_IDX_W    1
`define FIFO_DEPTH    16
`define FIFO_AW       4
`define FIFO_CNT_W    5

// mode codes held in the extended control register
`define MODE_SPP      3'h0
`define MODE_BIDIR    3'h1
`define MODE_FIFO     3'h2
`define MODE_ECP      3'h3
`define MODE_VEND_A   3'h4
`define MODE_VEND_B   3'h5

// configuration register a fields
`define CFGA_IRQ_LEVEL   1'h1
`define CFGA_IMP_ID      3'h0
`define CFGA_XCVR_BIT    1'h1
`define SNAP_FULL_WORD   2'h0

// interrupt status bit positions
`define IRQ_EMPTY     0
`define IRQ_STALL     1
`define IRQ_SNAP      2
`define IRQ_W         3

// reset values
`define DCR_RESET     8'h04
`define ECR_RESET     3'h0

`endif

// ---- inc/ecp_port_pkg.sv ----
// types shared by the ecp host port design
// assumes the defs header sits on the include path
`include "ecp_port_defs.svh"

package ecp_port_pkg;

  // device control register, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] rsvd;
    logic       dir;
    logic       ack_irq_en;
    logic       select_in;
    logic       init_n;
    logic       autofd;
    logic       strobe;
  } dcr_t;

  // byte on its way to the cable
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } tx_byte_t;

  // forward transmit engine states
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_STROBE,
    TX_RELEASE
  } tx_state_t;

endpackage

// ---- hw/ecp_fwd_fifo.sv ----
// port word fifo for the forward direction of the ecp host port
// assumes one clock, synchronous active high reset and a separate flush
`timescale 1ns/100ps
`include "ecp_port_defs.svh"

module ecp_fwd_fifo
  import ecp_port_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   flush_i,
  // fill side
  input  wire logic                   push_i,
  input  wire logic [`WORD_W-1:0]     push_data_i,
  output logic                        full_o,
  // drain side
  input  wire logic                   pop_i,
  output logic [`WORD_W-1:0]          head_o,
  output logic                        empty_o
);

  logic [`WORD_W-1:0]     mem_q [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0]    wr_ptr_q;
  logic [`FIFO_AW-1:0]    rd_ptr_q;
  logic [`FIFO_CNT_W-1:0] count_q;
  logic                   do_push;
  logic                   do_pop;

  // a push into a full fifo is dropped, which is how software sees the fill count
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign full_o  = (count_q == `FIFO_CNT_W'(`FIFO_DEPTH));
  assign empty_o = (count_q == '0);
  assign head_o  = mem_q[rd_ptr_q];

  // storage needs no reset, only pointers decide what is valid
  always_ff @(posedge clk_i)
  begin
    if (do_push)
    begin
      mem_q[wr_ptr_q] <= push_data_i;
    end
  end

  // pointers and fill count, flush empties it at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// ---- hw/ecp_host_port.sv ----
// ecp host port: registers, forward fifo, forward handshake and abort snapshot
// assumes a plain register port with read data one cycle after the read strobe,
// and cable inputs already synchronous to CLK_I
`timescale 1ns/100ps
`include "ecp_port_defs.svh"

// Operation
// R01 - snapshot 01/10/11 gives valid head-word bytes
// R02 - modes 100 and 101 are vendor functions
// R03 - host waits empty and busy low
// R04 - forced strobe stops all further transfers; the byte already on the pins can still be taken by the peripheral
// R05 - host counts fill writes until full
// R06 - head word may be partly sent
// R07 - mode 001 write resets fifo, captures snapshot
// R08 - direction bit tri-states data drivers
// R09 - host drops init, waits paper-end low
// R10 - host then releases strobe
// R11 - host raises init, waits paper-end high
// R12 - link ends in forward idle phase
// R13 - transceiver bit zero means extra byte
// R14 - snapshot meaningless on byte-wide port
// R15 - snapshot from last word on leaving ecp
// R16 - control bits override engine, force active
// R17 - transceiver bit one: full counts byte
// R18 - snapshot held until next fifo reset
module ecp_host_port
  import ecp_port_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // register port
  input  wire logic [2:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [7:0]       RDATA_O,
  // parallel data pins
  input  wire logic [7:0]  PDATA_I,
  output logic [7:0]       PDATA_O,
  output logic             PDATA_OE_O,
  // control lines to the peripheral
  output logic             STROBE_N_O,
  output logic             AUTOFD_N_O,
  output logic             INIT_N_O,
  output logic             SELECT_IN_N_O,
  // status lines from the peripheral
  input  wire logic        BUSY_I,
  input  wire logic        ACK_N_I,
  input  wire logic        PAPER_END_I,
  input  wire logic        SELECT_I,
  input  wire logic        FAULT_N_I,
  // interrupt
  output logic             IRQ_O
);

  dcr_t                      dcr_q;
  logic [2:0]                mode_q;
  logic [7:0]                data_latch_q;
  logic [1:0]                snap_q;
  logic [`IRQ_W-1:0]         int_stat_q;
  logic [`IRQ_W-1:0]         int_mask_q;
  logic [7:0]                rdata_q;
  tx_state_t                 tx_state_q;
  logic [`BYTE_IDX_W-1:0]    byte_idx_q;
  tx_byte_t                  tx_q;
  logic                      empty_d1_q;

  logic                      wr_data;
  logic                      wr_dcr;
  logic                      wr_ecr;
  logic                      wr_stat;
  logic                      wr_mask;
  logic                      fifo_flush;
  logic                      leave_ecp;
  logic                      fifo_push;
  logic                      fifo_pop;
  logic                      fifo_full;
  logic                      fifo_empty;
  logic [`WORD_W-1:0]        fifo_head;
  logic                      ecp_fwd;
  logic                      vend_drain;
  logic                      strobe_forced;
  logic                      last_byte;
  logic [7:0]                head_byte;
  logic [`IRQ_W-1:0]         int_event;
  logic [7:0]                rdata_d;

  // register write decode
  assign wr_data = WR_I && (ADDR_I == `REG_DATA);
  assign wr_dcr  = WR_I && (ADDR_I == `REG_DCR);
  assign wr_ecr  = WR_I && (ADDR_I == `REG_ECR);
  assign wr_stat = WR_I && (ADDR_I == `REG_INT_STAT);
  assign wr_mask = WR_I && (ADDR_I == `REG_INT_MASK);

  // any write that lands in mode 000 or 001 flushes the fifo; such a write that leaves ecp also snapshots
  assign fifo_flush = wr_ecr && ((WDATA_I[7:5] == `MODE_SPP) || (WDATA_I[7:5] == `MODE_BIDIR)); // R07
  assign leave_ecp  = fifo_flush && (mode_q == `MODE_ECP);                                   // R15

  // the data register fills the fifo in the fifo modes, software sees drops via full
  assign fifo_push = wr_data && ((mode_q == `MODE_ECP) || (mode_q == `MODE_FIFO)); // R05

  // engine runs only in forward ecp with drivers on
  assign ecp_fwd       = (mode_q == `MODE_ECP) && !dcr_q.dir;
  assign strobe_forced = dcr_q.strobe;

  // vendor mode 100 drains the fifo without cable traffic, 101 parks the port
  assign vend_drain = (mode_q == `MODE_VEND_A); // R02

  // select the byte of the head word that goes out next, low byte first
  assign head_byte = fifo_head[8*byte_idx_q +: 8];
  assign last_byte = (byte_idx_q == `BYTE_IDX_W'(`WORD_BYTES - 1));

  // outside vendor mode 100, a word leaves the fifo only once its last byte is acknowledged at event 35
  assign fifo_pop = (ecp_fwd && (tx_state_q == TX_STROBE) && BUSY_I && !strobe_forced && last_byte)
                  || (vend_drain && !fifo_empty); // R06

  ecp_fwd_fifo u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .flush_i     (fifo_flush),
    .push_i      (fifo_push),
    .push_data_i ({WDATA_I, WDATA_I}),
    .full_o      (fifo_full),
    .pop_i       (fifo_pop),
    .head_o      (fifo_head),
    .empty_o     (fifo_empty)
  );

  // device control register, direction only writable outside 000 and 010
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      dcr_q <= dcr_t'(`DCR_RESET);
    end
    else if (wr_dcr)
    begin
      dcr_q      <= dcr_t'(WDATA_I);
      dcr_q.rsvd <= 2'h0;
      if ((mode_q == `MODE_SPP) || (mode_q == `MODE_FIFO))
      begin
        dcr_q.dir <= 1'b0; // R08
      end
    end
  end

  // extended control register mode field
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      mode_q <= `ECR_RESET;
    end
    else if (wr_ecr)
    begin
      mode_q <= WDATA_I[7:5];
    end
  end

  // plain data latch for the non-fifo modes
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      data_latch_q <= 8'h00;
    end
    else if (wr_data && !fifo_push)
    begin
      data_latch_q <= WDATA_I;
    end
  end

  // forward handshake: strobe low, wait busy high, strobe high, wait busy low
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || fifo_flush)
    begin
      tx_state_q <= TX_IDLE; // R12
      byte_idx_q <= '0;
      tx_q       <= '0;
    end
    else if (ecp_fwd)
    begin
      unique case (tx_state_q)
        TX_IDLE:
        begin
          // a forced strobe freezes the engine so no new byte starts
          if (!fifo_empty && !strobe_forced) // R04
          begin
            tx_q.data  <= head_byte;
            tx_q.valid <= 1'b1;
            tx_state_q <= TX_STROBE;
          end
        end
        TX_STROBE:
        begin
          // event 35: peripheral took the byte; ignored once software forced strobe
          if (BUSY_I && !strobe_forced) // R04
          begin
            tx_q.valid <= 1'b0;
            byte_idx_q <= last_byte ? '0 : byte_idx_q + 1'b1; // R06
            tx_state_q <= TX_RELEASE;
          end
        end
        TX_RELEASE:
        begin
          if (!BUSY_I)
          begin
            tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // head word snapshot, count of still valid bytes in a partly sent word
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      snap_q <= `SNAP_FULL_WORD;
    end
    else if (leave_ecp) // R18
    begin
      if (byte_idx_q == '0)
      begin
        snap_q <= `SNAP_FULL_WORD;
      end
      else
      begin
        // only 1 -> 01 occurs: one valid byte left in the two-byte head word
        snap_q <= 2'(`WORD_BYTES - int'(byte_idx_q)); // R01
      end
    end
  end

  // interrupt events: fifo drained in ecp, stall with strobe forced, snapshot taken
  always_comb
  begin
    int_event             = '0;
    int_event[`IRQ_EMPTY] = fifo_empty && !empty_d1_q && (mode_q == `MODE_ECP);
    int_event[`IRQ_STALL] = wr_dcr && WDATA_I[0] && (tx_state_q == TX_STROBE);
    int_event[`IRQ_SNAP]  = leave_ecp;
  end

  // edge memory for the empty event
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      empty_d1_q <= 1'b1;
    end
    else
    begin
      empty_d1_q <= fifo_empty;
    end
  end

  // sticky status, write one to clear; a new event in the clear cycle wins
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      int_stat_q <= '0;
    end
    else
    begin
      int_stat_q <= (int_stat_q & ~(wr_stat ? WDATA_I[`IRQ_W-1:0] : '0)) | int_event;
    end
  end

  // interrupt mask
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      int_mask_q <= '0;
    end
    else if (wr_mask)
    begin
      int_mask_q <= WDATA_I[`IRQ_W-1:0];
    end
  end

  assign IRQ_O = |(int_stat_q & int_mask_q);

  // read mux; the status byte shows busy so software can check drain before resend
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (ADDR_I)
      `REG_DATA:     rdata_d = PDATA_I;
      `REG_DSR:      rdata_d = {BUSY_I, ACK_N_I, PAPER_END_I, SELECT_I, FAULT_N_I, 3'h0}; // R03
      `REG_DCR:      rdata_d = {2'h0, dcr_q[5:0]};
      // transceiver bit is 1: the byte in flight still counts in full, so no extra byte
      `REG_CFGA:     rdata_d = {`CFGA_IRQ_LEVEL, `CFGA_IMP_ID, 1'h0, `CFGA_XCVR_BIT, snap_q}; // R13 R17 R14
      `REG_ECR:      rdata_d = {mode_q, 3'h0, fifo_full, fifo_empty};
      `REG_INT_STAT: rdata_d = {5'h00, int_stat_q};
      `REG_INT_MASK: rdata_d = {5'h00, int_mask_q};
      default:       rdata_d = 8'h00;
    endcase
  end

  // read data stands for one cycle after the read strobe only
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= RD_I ? rdata_d : 8'h00;
    end
  end

  assign RDATA_O = rdata_q;

  // data pins: always driven in 000 and 010, otherwise released by the direction bit
  assign PDATA_O    = (mode_q == `MODE_ECP) ? tx_q.data : data_latch_q;
  assign PDATA_OE_O = (mode_q == `MODE_SPP) || (mode_q == `MODE_FIFO) || !dcr_q.dir; // R08

  // control bits win over the engine and force their line active
  assign STROBE_N_O    = !(dcr_q.strobe || (ecp_fwd && tx_q.valid && (tx_state_q == TX_STROBE))); // R16
  assign AUTOFD_N_O    = !dcr_q.autofd; // R16
  assign INIT_N_O      = dcr_q.init_n;
  assign SELECT_IN_N_O = !dcr_q.select_in;

endmodule

// ---- testbench/ecp_port_properties.sv ----
// checker for the ecp host port, watching its top-level ports only
// assumes it is bound into ecp_host_port; one clock, sync reset
`timescale 1ns/100ps
module ecp_port_properties
  import ecp_port_pkg::*;
(
  // clock and reset
  input wire logic       CLK_I,
  input wire logic       RST_I,
  // register port
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  // cable side
  input wire logic [7:0] PDATA_O,
  input wire logic       PDATA_OE_O,
  input wire logic       STROBE_N_O
);
  logic [2:0] mode_q;
  logic [1:0] snap_q;
  logic       force_q;
  logic       rd3_q;
  logic       seen_q;
  wire        wr_ecr = WR_I && ADDR_I == 3'h4;
  wire        wr_dcr = WR_I && ADDR_I == 3'h2;
  wire        rd_ecr = RD_I && ADDR_I == 3'h4;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  // shadow of mode and forced strobe; a mode write may move the snapshot
  always_ff @(posedge CLK_I)
  begin
    rd3_q <= !RST_I && RD_I && ADDR_I == 3'h3;
    if (rd3_q)
      snap_q <= RDATA_O[1:0];
    if (RST_I)
    begin
      mode_q  <= 3'h0;
      force_q <= 1'b0;
      seen_q  <= 1'b0;
    end
    else
    begin
      if (wr_ecr)
        mode_q <= WDATA_I[7:5];
      if (wr_dcr)
        force_q <= WDATA_I[0];
      seen_q <= (seen_q || rd3_q) && !wr_ecr;
    end
  end

  xcvr_bit_a: assert property (RD_I && ADDR_I == 3'h3 |=> RDATA_O[7:2] == 6'h21)
    else $error("config a fixed bits wrong");
  snap_range_a: assert property (rd3_q |-> !RDATA_O[1])
    else $error("snapshot beyond word size");
  snap_hold_a: assert property (rd3_q && seen_q |-> RDATA_O[1:0] == snap_q)
    else $error("snapshot moved without mode write");
  mode_read_a: assert property (rd_ecr |=> RDATA_O[7:5] == mode_q)
    else $error("mode readback wrong");
  flush_empty_a: assert property (wr_ecr && WDATA_I[7:5] == 3'h1 ##2 rd_ecr |=> RDATA_O[0])
    else $error("fifo not empty after mode 001");
  strobe_force_a: assert property (wr_dcr && WDATA_I[0] |=> !STROBE_N_O)
    else $error("forced strobe not low");
  dir_tristate_a: assert property (wr_dcr && WDATA_I[5] && !(mode_q inside {3'h0, 3'h2}) |=> !PDATA_OE_O)
    else $error("data pins still driven");
  tx_frozen_a: assert property (force_q && mode_q == 3'h3 && $past(force_q && mode_q == 3'h3) |-> $stable(PDATA_O))
    else $error("byte moved under forced strobe");

  // main scenarios reached
  cover property (rd3_q && RDATA_O[0]);
  cover property (force_q && mode_q == 3'h3 && !STROBE_N_O);
  cover property (wr_dcr && WDATA_I[5] && mode_q == 3'h1);
endmodule

bind ecp_host_port ecp_port_properties i_ecp_port_properties (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .PDATA_O, .PDATA_OE_O, .STROBE_N_O);

// ---- testbench/ecp_peripheral_model.sv ----
// peripheral model on the far end of the host port cable
// assumes cable levels sampled on the host clock, no cable delay
`timescale 1ns/100ps
module ecp_peripheral_model
  import ecp_port_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // host lines and bench controls
  input  wire logic       strobe_n_i,
  input  wire logic       init_n_i,
  input  wire logic [7:0] data_i,
  input  wire logic [3:0] dly_i,
  input  wire logic [7:0] lim_i,
  // peripheral lines and received data
  output logic            busy_o,
  output logic            pe_o,
  output logic [7:0]      rx_byte_o,
  output logic [7:0]      rx_cnt_o
);
  logic [3:0] wait_q;

  // byte taken after dly_i cycles of strobe low; stalls once lim_i bytes are in
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o   <= 1'b0;
      wait_q   <= 4'h0;
      rx_cnt_o <= 8'h00;
    end
    else if (!busy_o && !strobe_n_i && rx_cnt_o != lim_i)
    begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= dly_i)
      begin
        busy_o    <= 1'b1;
        rx_byte_o <= data_i;
        rx_cnt_o  <= rx_cnt_o + 8'h01;
        wait_q    <= 4'h0;
      end
    end
    else if (strobe_n_i)
      busy_o <= 1'b0;
  end

  // paper-end answers init one cycle late during recovery
  always_ff @(posedge clk_i)
    pe_o <= rst_i | init_n_i;
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the ecp host port against a peripheral model
// assumes package, defs header, design, checker and model compiled first
`timescale 1ns/100ps
module tb
  import ecp_port_pkg::*;
();
  logic       clk = 1'b0;
  logic       rst, wr, rd, oe, busy, pe, ack_n, sel, fault_n, strobe_n, init_n, irq, autofd_n, selin_n;
  logic [2:0] addr;
  logic [3:0] dly;
  logic [7:0] wdata, rdata, pdata, rx_byte, rx_cnt, lim, v, b;
  int         fails, n_tests, i, k;

  always #12.5 clk = ~clk;

  // released data pins show the inverse of the last byte, not a stale copy
  ecp_host_port i_ecp_host_port (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .PDATA_I(oe ? pdata : ~pdata), .PDATA_O(pdata), .PDATA_OE_O(oe), .STROBE_N_O(strobe_n),
    .AUTOFD_N_O(autofd_n), .INIT_N_O(init_n), .SELECT_IN_N_O(selin_n), .BUSY_I(busy), .ACK_N_I(ack_n),
    .PAPER_END_I(pe), .SELECT_I(sel), .FAULT_N_I(fault_n), .IRQ_O(irq));
  ecp_peripheral_model i_ecp_peripheral_model (.clk_i(clk), .rst_i(rst), .strobe_n_i(strobe_n), .init_n_i(init_n),
    .data_i(pdata), .dly_i(dly), .lim_i(lim), .busy_o(busy), .pe_o(pe), .rx_byte_o(rx_byte), .rx_cnt_o(rx_cnt));

  // expected config a: level irq, 16-bit id, no transceiver byte, snapshot
  function automatic logic [7:0] cfga_exp(input logic [1:0] snap);
    return {1'b1, 3'h0, 1'b0, 1'b1, snap};
  endfunction

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  // one-cycle register strobes, driven just after the edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e, input string what);
    rd_reg(a);
    check(what, e, v);
  endtask
  // delivered only once fifo empty, strobe back high and busy low
  task automatic drain;
    for (k = 0; k < 200; k++)
    begin
      rd_reg(3'h4);
      if (v[0] === 1'b1 && busy === 1'b0 && strobe_n === 1'b1)
        break;
    end
  endtask
  task automatic wait_pe(input logic lvl);
    for (k = 0; k < 100 && pe !== lvl; k++)
      @(posedge clk);
    chk_bit("paper end", lvl, pe);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the run needs well under a thousand of the 40000 cycles allowed
  initial
  begin
    #1000000;
    fails++;
    results;
  end

  initial
  begin
    {addr, wdata, wr, rd, ack_n, sel, fault_n, dly, lim} = '0;
    rst = 1'b1;
    fails = 0;
    n_tests = 0;
    k = $urandom(39);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_reg(3'h3, cfga_exp(2'h0), "config a");
    chk_reg(3'h7, 8'h00, "unmapped");
    // every mode code reads back, vendor codes included
    for (i = 0; i < 6; i++)
    begin
      wr_reg(3'h4, {3'(i), 5'h00});
      chk_reg(3'h4, {3'(i), 5'h01}, "mode");
    end
    // vendor mode 100 empties what mode 010 queued, with no cable traffic
    wr_reg(3'h4, 8'h40);
    wr_reg(3'h0, 8'h11);
    wr_reg(3'h0, 8'h22);
    chk_reg(3'h4, 8'h40, "queued");
    wr_reg(3'h4, 8'h80);
    @(posedge clk);
    chk_reg(3'h4, 8'h81, "vendor drain");
    check("no cable bytes", 8'h00, rx_cnt);
    // random words at random peripheral speed, status lines random
    wr_reg(3'h4, 8'h60);
    for (i = 0; i < 12; i++)
    begin
      @(posedge clk);
      {ack_n, sel, fault_n} <= 3'($urandom);
      dly <= 4'($urandom % 6);
      lim <= rx_cnt + 8'h02;
      b = 8'($urandom);
      wr_reg(3'h0, b);
      drain;
      check("rx byte", b, rx_byte);
      check("rx count", lim, rx_cnt);
      chk_reg(3'h1, {1'b0, ack_n, pe, sel, fault_n, 3'h0}, "dsr");
    end
    // fifo-empty event: masked, unmasked, cleared by writing one
    rd_reg(3'h5);
    chk_bit("empty event", 1'b1, v[0]);
    chk_bit("irq masked", 1'b0, irq);
    wr_reg(3'h6, 8'h01);
    #1 chk_bit("irq on", 1'b1, irq);
    wr_reg(3'h5, 8'hFF);
    #1 chk_bit("irq cleared", 1'b0, irq);
    wr_reg(3'h6, 8'h06);
    // peripheral takes byte 0 then stalls; host forces strobe, peripheral resumes
    @(posedge clk);
    lim <= rx_cnt + 8'h01;
    wr_reg(3'h0, 8'hC3);
    repeat (20) @(posedge clk);
    chk_bit("stalled strobe", 1'b0, strobe_n);
    wr_reg(3'h2, 8'h05);
    @(posedge clk);
    lim <= lim + 8'h04;
    repeat (10) @(posedge clk);
    // the peripheral may grab the byte on the pins, but the engine starts no other
    check("bytes after force", lim - 8'h03, rx_cnt);
    // fill until full; one word was left, so depth less one writes
    for (i = 0; i < 20; i++)
    begin
      rd_reg(3'h4);
      if (v[1] === 1'b1)
        break;
      wr_reg(3'h0, 8'($urandom));
    end
    check("fill writes", 8'h0F, 8'(i));
    wr_reg(3'h4, 8'h20);
    chk_reg(3'h4, 8'h21, "flushed");
    chk_reg(3'h3, cfga_exp(2'h1), "snapshot");
    rd_reg(3'h5);
    check("events", 8'h06, v & 8'h06);
    chk_bit("irq", 1'b1, irq);
    wr_reg(3'h5, 8'h06);
    // recovery handshake
    wr_reg(3'h2, 8'h25);
    #1 chk_bit("data drive", 1'b0, oe);
    wr_reg(3'h2, 8'h21);
    wait_pe(1'b0);
    wr_reg(3'h2, 8'h20);
    #1 chk_bit("strobe", 1'b1, strobe_n);
    wr_reg(3'h2, 8'h24);
    wait_pe(1'b1);
    chk_bit("busy idle", 1'b0, busy);
    chk_reg(3'h3, cfga_exp(2'h1), "held snapshot");
    // a whole word sent before leaving 011 gives snapshot 00
    wr_reg(3'h2, 8'h04);
    wr_reg(3'h4, 8'h60);
    @(posedge clk);
    lim <= rx_cnt + 8'h02;
    wr_reg(3'h0, 8'h5A);
    drain;
    wr_reg(3'h4, 8'h00);
    chk_reg(3'h3, cfga_exp(2'h0), "new snapshot");
    // mode 000: the latch drives the pins and reads back through them
    wr_reg(3'h0, 8'hA5);
    chk_reg(3'h0, 8'hA5, "pins driven");
    check("data pins", 8'hA5, pdata);
    wr_reg(3'h2, 8'h0E);
    #1 chk_bit("autofeed", 1'b0, autofd_n);
    chk_bit("select in", 1'b0, selin_n);
    chk_bit("init", 1'b1, init_n);
    // mode 001 with direction set: released pins read back the far side
    wr_reg(3'h4, 8'h20);
    wr_reg(3'h2, 8'h24);
    chk_reg(3'h0, 8'h5A, "released pins");
    results;
  end
endmodule
